// >>> rtl/smbus_target.sv
/*
 * Serial management bus target: synchronises the bus pins, finds start and
 * stop conditions, matches the target address and turns write-byte,
 * read-byte, send-byte and receive-byte transfers into register accesses.
 * Assumes the bus clock is far slower than clk_sys_in.
 */
`timescale 1ns/1ps
module smbus_target
#(
	parameter logic [6:0] ADDRESS = temp_limit_pkg::TARGET_ADDRESS
)
(
	// Clock and reset
	input  wire logic                        clk_sys_in,
	input  wire logic                        rst_n_in,
	// Bus pins
	input  wire logic                        scl_in,
	input  wire logic                        sda_in,
	output logic                             sda_out,
	output logic                             sda_oe_out,
	// Register side
	output temp_limit_pkg::reg_access_t      access_out,
	input  wire logic [7:0]                  rd_data_in
);
	import temp_limit_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_ACK  = 3'b011,
		ST_TX   = 3'b010,
		ST_RACK = 3'b110
	} bus_state_t;

	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic       scl_prev_q;
	logic       sda_prev_q;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_cond;
	logic       stop_cond;
	bus_state_t state_q;
	logic [7:0] shift_q;
	logic [3:0] bit_q;
	logic [1:0] byte_q;
	logic       read_q;
	logic       nack_q;
	logic [7:0] ptr_q;
	logic       wr_q;
	logic       rd_q;
	logic [7:0] wr_data_q;

	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
		begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end
		else
		begin
			scl_sync_q <= {scl_sync_q[0], scl_in};
			sda_sync_q <= {sda_sync_q[0], sda_in};
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end
	end

	assign scl_rise   = scl_sync_q[1] & ~scl_prev_q;
	assign scl_fall   = ~scl_sync_q[1] & scl_prev_q;
	assign start_cond = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
	assign stop_cond  = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];

	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
		begin
			state_q   <= ST_IDLE;
			shift_q   <= 8'h00;
			bit_q     <= 4'h0;
			byte_q    <= 2'h0;
			read_q    <= 1'b0;
			nack_q    <= 1'b0;
			ptr_q     <= 8'h00;
			wr_q      <= 1'b0;
			rd_q      <= 1'b0;
			wr_data_q <= 8'h00;
		end
		else
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			if (start_cond)
			begin
				state_q <= ST_RX;
				bit_q   <= 4'h0;
				byte_q  <= 2'h0;
			end
			else if (stop_cond)
				state_q <= ST_IDLE;
			else
			begin
				unique case (state_q)
					ST_IDLE: ;
					ST_RX:
					begin
						if (scl_rise)
						begin
							shift_q <= {shift_q[6:0], sda_sync_q[1]};
							bit_q   <= bit_q + 4'h1;
						end
						else if (scl_fall && bit_q == 4'h8)
						begin
							bit_q   <= 4'h0;
							state_q <= ST_ACK;
							if (byte_q == 2'h0)
							begin
								read_q <= shift_q[0];
								if (shift_q[7:1] != ADDRESS)
									state_q <= ST_IDLE;
							end
							else if (byte_q == 2'h1)
								ptr_q <= shift_q;
							else
							begin
								wr_q      <= 1'b1;
								wr_data_q <= shift_q;
							end
						end
					end
					ST_ACK:
					begin
						if (scl_fall)
						begin
							if (byte_q != 2'h3)
								byte_q <= byte_q + 2'h1;
							if (byte_q == 2'h0 && read_q)
							begin
								state_q <= ST_TX;
								shift_q <= rd_data_in;
								rd_q    <= 1'b1;
							end
							else
								state_q <= ST_RX;
						end
					end
					ST_TX:
					begin
						if (scl_fall)
						begin
							if (bit_q == 4'h7)
							begin
								bit_q   <= 4'h0;
								state_q <= ST_RACK;
							end
							else
							begin
								bit_q   <= bit_q + 4'h1;
								shift_q <= {shift_q[6:0], 1'b0};
							end
						end
					end
					ST_RACK:
					begin
						if (scl_rise)
							nack_q <= sda_sync_q[1];
						else if (scl_fall)
						begin
							if (nack_q)
								state_q <= ST_IDLE;
							else
							begin
								state_q <= ST_TX;
								shift_q <= rd_data_in;
								rd_q    <= 1'b1;
							end
						end
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// The pin is only ever pulled low; a one is sent by releasing it.
	assign sda_out    = 1'b0;
	assign sda_oe_out = (state_q == ST_ACK) | ((state_q == ST_TX) & ~shift_q[7]);

	assign access_out = '{wr: wr_q, rd: rd_q, ptr: ptr_q, data: wr_data_q};

endmodule

// >>> rtl/temp_limit_pkg.sv
/*
 * Shared constants and types for the temperature limit and shutdown logic:
 * register offsets, reset values, channel layout and the packed types that
 * carry temperatures and register accesses between the two design modules.
 * Assumes nothing of its surroundings.
 */
package temp_limit_pkg;

	localparam int unsigned CHANNELS = 4;
	localparam int unsigned FRAC_W   = 3;

	// Register offsets.
	localparam logic [7:0] OFS_INT_HIGH      = 8'h05;
	localparam logic [7:0] OFS_INT_HIGH_ALT  = 8'h0B;
	localparam logic [7:0] OFS_INT_LOW       = 8'h06;
	localparam logic [7:0] OFS_INT_LOW_ALT   = 8'h0C;
	localparam logic [7:0] OFS_R1_HIGH_INT   = 8'h07;
	localparam logic [7:0] OFS_R1_HIGH_ALT   = 8'h0D;
	localparam logic [7:0] OFS_R1_LOW_INT    = 8'h08;
	localparam logic [7:0] OFS_R1_LOW_ALT    = 8'h0E;
	localparam logic [7:0] OFS_SCRATCH_0     = 8'h11;
	localparam logic [7:0] OFS_SCRATCH_1     = 8'h12;
	localparam logic [7:0] OFS_R1_HIGH_FRAC  = 8'h13;
	localparam logic [7:0] OFS_R1_LOW_FRAC   = 8'h14;
	localparam logic [7:0] OFS_R2_HIGH_INT   = 8'h15;
	localparam logic [7:0] OFS_R2_LOW_INT    = 8'h16;
	localparam logic [7:0] OFS_R2_HIGH_FRAC  = 8'h17;
	localparam logic [7:0] OFS_R2_LOW_FRAC   = 8'h18;
	localparam logic [7:0] OFS_R1_CRIT       = 8'h19;
	localparam logic [7:0] OFS_R2_CRIT       = 8'h1A;
	localparam logic [7:0] OFS_FAULT_FLAGS   = 8'h1B;
	localparam logic [7:0] OFS_SHUTDOWN_LINK = 8'h1D;
	localparam logic [7:0] OFS_INT_CRIT      = 8'h20;
	localparam logic [7:0] OFS_HYSTERESIS    = 8'h21;
	localparam logic [7:0] OFS_R3_HIGH_INT   = 8'h2C;
	localparam logic [7:0] OFS_R3_LOW_INT    = 8'h2D;
	localparam logic [7:0] OFS_R3_HIGH_FRAC  = 8'h2E;
	localparam logic [7:0] OFS_R3_LOW_FRAC   = 8'h2F;
	localparam logic [7:0] OFS_R3_CRIT       = 8'h30;

	// Reset values.
	localparam logic [7:0] RST_HIGH_INT   = 8'h55;
	localparam logic [7:0] RST_LOW_INT    = 8'h00;
	localparam logic [7:0] RST_FRAC       = 8'h00;
	localparam logic [7:0] RST_CRIT       = 8'h55;
	localparam logic [7:0] RST_HYSTERESIS = 8'h0A;
	localparam logic [7:0] RST_SCRATCH    = 8'h00;
	localparam logic [3:0] RST_LINK       = 4'h0;
	localparam logic [3:0] RST_FAULT      = 4'h0;

	// Field positions, unmapped read value and target address.
	localparam int unsigned FRAC_LSB       = 5;
	localparam int unsigned FAULT_FIRST    = 1;
	localparam logic [3:0]  FAULT_MASK     = 4'hE;
	localparam logic [7:0]  READ_UNMAPPED  = 8'h00;
	localparam logic [6:0]  TARGET_ADDRESS = 7'h4C;

	// Temperature: integer byte and left-justified three fraction bits.
	typedef struct packed {
		logic [7:0]        whole;
		logic [FRAC_W-1:0] frac;
	} temp_t;

	// One register access from the serial target.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] ptr;
		logic [7:0] data;
	} reg_access_t;

endpackage

// >>> rtl/temp_limit_shutdown.sv
/*
 * Limit comparison and shutdown logic of a four-channel temperature
 * monitor, with its register file reached over the serial management bus.
 * Assumes the conversion engine presents each stored result with a one-cycle
 * strobe on clk_sys_in, and that the status logic outside clears the
 * per-channel status flags with a one-cycle pulse.
 */
`timescale 1ns/1ps
// Operation
// - Temperature above high limit sets that channel's high flag and alert.
// - Temperature at or below low limit sets low flag and alert.
// - Every channel has its own high and low limit.
// - Doubly mapped limit registers are one register at both addresses.
// - Two scratch registers reset to zero and return what was written.
// - Temperature above critical limit drives shutdown only when linked.
// - Fault flags bits 3..1 name the faulty remote diode; others read zero.
// - Reading the fault flags returns them then clears all but faults reported in the clear cycle.
// - Link register holds one enable per channel, all reset to zero.
// - Each linked channel compares against its own critical limit.
// - Unlinked channel above critical sets status but never shutdown.
// - Shutdown holds until temperature falls below critical minus hysteresis.
// - Linked requests are combined with the hardware shutdown source.
// - Range zero is plain binary, range one offset binary.
// - Temperatures are eleven bits: integer byte plus three fraction bits.
module temp_limit_shutdown
#(
	parameter int unsigned CH     = temp_limit_pkg::CHANNELS,
	parameter logic [6:0] ADDRESS = temp_limit_pkg::TARGET_ADDRESS
)
(
	// Clock and reset
	input  wire logic                             clk_sys_in,
	input  wire logic                             rst_n_in,
	// Serial management bus pins
	input  wire logic                             scl_in,
	input  wire logic                             sda_in,
	output logic                                  sda_out,
	output logic                                  sda_oe_out,
	// Conversion results
	input  wire temp_limit_pkg::temp_t [CH-1:0]   temp_in,
	input  wire logic [CH-1:0]                    temp_valid_in,
	input  wire logic [CH-1:0]                    diode_fault_in,
	input  wire logic                             range_in,
	// Status logic
	input  wire logic                             status_clear_in,
	input  wire logic                             hw_shutdown_in,
	output logic [CH-1:0]                         high_status_out,
	output logic [CH-1:0]                         low_status_out,
	output logic [CH-1:0]                         critical_status_out,
	output logic                                  fault_summary_out,
	// System pins
	output logic                                  alert_out_n,
	output logic                                  shutdown_out_n
);
	import temp_limit_pkg::*;

	reg_access_t access;
	logic [7:0]  rd_data;
	logic [7:0]  high_int_q [CH];
	logic [7:0]  high_frac_q [CH];
	logic [7:0]  low_int_q [CH];
	logic [7:0]  low_frac_q [CH];
	logic [7:0]  crit_q [CH];
	logic [7:0]  hyst_q;
	logic [7:0]  scratch_q [2];
	logic [3:0]  link_q;
	logic [3:0]  fault_q;
	logic [CH-1:0] high_q;
	logic [CH-1:0] low_q;
	logic [CH-1:0] crit_stat_q;
	logic [CH-1:0] shut_q;
	logic        range_q;
	logic        alert_n_q;
	logic        shutdown_n_q;

	smbus_target #(
		.ADDRESS    (ADDRESS)
	) u_target (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.scl_in     (scl_in),
		.sda_in     (sda_in),
		.sda_out    (sda_out),
		.sda_oe_out (sda_oe_out),
		.access_out (access),
		.rd_data_in (rd_data)
	);

	// Register writes; the alias offsets decode to the same flops.
	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < CH; i++)
			begin
				high_int_q[i]  <= RST_HIGH_INT;
				high_frac_q[i] <= RST_FRAC;
				low_int_q[i]   <= RST_LOW_INT;
				low_frac_q[i]  <= RST_FRAC;
				crit_q[i]      <= RST_CRIT;
			end
			hyst_q       <= RST_HYSTERESIS;
			scratch_q[0] <= RST_SCRATCH;
			scratch_q[1] <= RST_SCRATCH;
			link_q       <= RST_LINK;
		end
		else if (access.wr)
		begin
			unique case (access.ptr)
				OFS_INT_HIGH, OFS_INT_HIGH_ALT: high_int_q[0] <= access.data;
				OFS_INT_LOW, OFS_INT_LOW_ALT:   low_int_q[0]  <= access.data;
				OFS_R1_HIGH_INT, OFS_R1_HIGH_ALT: high_int_q[1] <= access.data;
				OFS_R1_LOW_INT, OFS_R1_LOW_ALT:   low_int_q[1]  <= access.data;
				OFS_R1_HIGH_FRAC: high_frac_q[1] <= {access.data[7:FRAC_LSB], 5'h00};
				OFS_R1_LOW_FRAC:  low_frac_q[1]  <= {access.data[7:FRAC_LSB], 5'h00};
				OFS_R2_HIGH_INT:  high_int_q[2]  <= access.data;
				OFS_R2_LOW_INT:   low_int_q[2]   <= access.data;
				OFS_R2_HIGH_FRAC: high_frac_q[2] <= {access.data[7:FRAC_LSB], 5'h00};
				OFS_R2_LOW_FRAC:  low_frac_q[2]  <= {access.data[7:FRAC_LSB], 5'h00};
				OFS_R3_HIGH_INT:  high_int_q[3]  <= access.data;
				OFS_R3_LOW_INT:   low_int_q[3]   <= access.data;
				OFS_R3_HIGH_FRAC: high_frac_q[3] <= {access.data[7:FRAC_LSB], 5'h00};
				OFS_R3_LOW_FRAC:  low_frac_q[3]  <= {access.data[7:FRAC_LSB], 5'h00};
				OFS_INT_CRIT:     crit_q[0]      <= access.data;
				OFS_R1_CRIT:      crit_q[1]      <= access.data;
				OFS_R2_CRIT:      crit_q[2]      <= access.data;
				OFS_R3_CRIT:      crit_q[3]      <= access.data;
				OFS_HYSTERESIS:   hyst_q         <= access.data;
				OFS_SCRATCH_0:    scratch_q[0]   <= access.data;
				OFS_SCRATCH_1:    scratch_q[1]   <= access.data;
				OFS_SHUTDOWN_LINK: link_q        <= access.data[3:0];
				default: ;
			endcase
		end
	end

	// Register reads; unmapped offsets and reserved bits read zero.
	always_comb
	begin
		unique case (access.ptr)
			OFS_INT_HIGH, OFS_INT_HIGH_ALT:   rd_data = high_int_q[0];
			OFS_INT_LOW, OFS_INT_LOW_ALT:     rd_data = low_int_q[0];
			OFS_R1_HIGH_INT, OFS_R1_HIGH_ALT: rd_data = high_int_q[1];
			OFS_R1_LOW_INT, OFS_R1_LOW_ALT:   rd_data = low_int_q[1];
			OFS_R1_HIGH_FRAC:  rd_data = high_frac_q[1];
			OFS_R1_LOW_FRAC:   rd_data = low_frac_q[1];
			OFS_R2_HIGH_INT:   rd_data = high_int_q[2];
			OFS_R2_LOW_INT:    rd_data = low_int_q[2];
			OFS_R2_HIGH_FRAC:  rd_data = high_frac_q[2];
			OFS_R2_LOW_FRAC:   rd_data = low_frac_q[2];
			OFS_R3_HIGH_INT:   rd_data = high_int_q[3];
			OFS_R3_LOW_INT:    rd_data = low_int_q[3];
			OFS_R3_HIGH_FRAC:  rd_data = high_frac_q[3];
			OFS_R3_LOW_FRAC:   rd_data = low_frac_q[3];
			OFS_INT_CRIT:      rd_data = crit_q[0];
			OFS_R1_CRIT:       rd_data = crit_q[1];
			OFS_R2_CRIT:       rd_data = crit_q[2];
			OFS_R3_CRIT:       rd_data = crit_q[3];
			OFS_HYSTERESIS:    rd_data = hyst_q;
			OFS_SCRATCH_0:     rd_data = scratch_q[0];
			OFS_SCRATCH_1:     rd_data = scratch_q[1];
			OFS_SHUTDOWN_LINK: rd_data = {4'h0, link_q};
			OFS_FAULT_FLAGS:   rd_data = {4'h0, fault_q & FAULT_MASK};
			default:           rd_data = READ_UNMAPPED;
		endcase
	end

	// A fault reported in the cycle the flags are read survives the clear.
	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
			fault_q <= RST_FAULT;
		else
		begin
			logic [3:0] set_v;
			set_v = (temp_valid_in[3:0] & diode_fault_in[3:0]) & FAULT_MASK;
			if (access.rd && access.ptr == OFS_FAULT_FLAGS)
				fault_q <= set_v;
			else
				fault_q <= fault_q | set_v;
		end
	end

	// The range bit only selects how software reads the codes; offset binary
	// keeps unsigned order, so one unsigned comparator serves both ranges.
	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
			range_q <= 1'b0;
		else
			range_q <= range_in;
	end

	generate
		for (genvar c = 0; c < CH; c++)
		begin : g_channel
			temp_t t;
			temp_t high_lim;
			temp_t low_lim;
			temp_t crit_lim;
			temp_t release_lim;
			logic  over_high;
			logic  at_low;
			logic  over_crit;
			logic  below_release;

			assign t        = temp_in[c];
			// The internal channel keeps no fraction bytes, so its limits are whole.
			assign high_lim = '{whole: high_int_q[c],
				frac: (c == 0) ? 3'h0 : high_frac_q[c][7:FRAC_LSB]};
			assign low_lim  = '{whole: low_int_q[c],
				frac: (c == 0) ? 3'h0 : low_frac_q[c][7:FRAC_LSB]};
			assign crit_lim = '{whole: crit_q[c], frac: 3'h0};
			// Saturate so a hysteresis above the limit cannot wrap upward.
			assign release_lim = '{whole: (crit_q[c] > hyst_q) ? 8'(crit_q[c] - hyst_q)
				: 8'h00, frac: 3'h0};

			assign over_high     = t > high_lim;
			assign at_low        = t <= low_lim;
			assign over_crit     = t > crit_lim;
			assign below_release = t < release_lim;

			always_ff @(posedge clk_sys_in)
			begin
				if (!rst_n_in)
				begin
					high_q[c]      <= 1'b0;
					low_q[c]       <= 1'b0;
					crit_stat_q[c] <= 1'b0;
				end
				else
				begin
					// A new result wins over a clear in the same cycle.
					high_q[c]      <= (high_q[c] & ~status_clear_in)
						| (temp_valid_in[c] & over_high);
					low_q[c]       <= (low_q[c] & ~status_clear_in)
						| (temp_valid_in[c] & at_low);
					crit_stat_q[c] <= (crit_stat_q[c] & ~status_clear_in)
						| (temp_valid_in[c] & over_crit);
				end
			end

			always_ff @(posedge clk_sys_in)
			begin
				if (!rst_n_in)
					shut_q[c] <= 1'b0;
				else if (!link_q[c])
					shut_q[c] <= 1'b0;
				else if (temp_valid_in[c])
				begin
					if (over_crit)
						shut_q[c] <= 1'b1;
					else if (below_release)
						shut_q[c] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_in)
	begin
		if (!rst_n_in)
		begin
			alert_n_q    <= 1'b1;
			shutdown_n_q <= 1'b1;
		end
		else
		begin
			alert_n_q    <= ~(|high_q | |low_q | |fault_q);
			shutdown_n_q <= ~(|(shut_q & link_q[CH-1:0]) | hw_shutdown_in);
		end
	end

	assign high_status_out     = high_q;
	assign low_status_out      = low_q;
	assign critical_status_out = crit_stat_q;
	assign fault_summary_out   = |fault_q;
	assign alert_out_n         = alert_n_q;
	assign shutdown_out_n      = shutdown_n_q;

endmodule

// >>> tb/smbus_host_model.sv
/*
 * Bus host model: drives the serial clock and pulls the data wire low.
 * Assumes a pull-up on the data wire outside; the clock idles high.
 */
`timescale 1ns/1ps
module smbus_host_model
(
	// Bus pins
	output logic      scl_out,
	output logic      pull_out,
	input  wire logic sda_in
);
	import temp_limit_pkg::*;

	initial
	begin
		scl_out = 1'b1;
		pull_out = 1'b0;
	end

	// Data changes mid-low so the target never sees it move under a high clock.
	task automatic put_bit(input logic b);
		#40 pull_out = !b;
		#40 scl_out = 1'b1;
		#80 scl_out = 1'b0;
	endtask

	task automatic get_bit(output logic b);
		#40 pull_out = 1'b0;
		#40 scl_out = 1'b1;
		#40 b = sda_in;
		#40 scl_out = 1'b0;
	endtask

	task automatic start_cond;
		#40 pull_out = 1'b0;
		#40 scl_out = 1'b1;
		#40 pull_out = 1'b1;
		#40 scl_out = 1'b0;
	endtask

	task automatic stop_cond;
		#40 pull_out = 1'b1;
		#40 scl_out = 1'b1;
		#40 pull_out = 1'b0;
		#40;
	endtask

	task automatic put_byte(input logic [7:0] d, inout logic ok);
		logic b;
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(b);
		ok = ok & !b;
	endtask

	task automatic reg_write(input logic [7:0] p, input logic [7:0] d, output logic ok);
		ok = 1'b1;
		start_cond();
		put_byte({TARGET_ADDRESS, 1'b0}, ok);
		put_byte(p, ok);
		put_byte(d, ok);
		stop_cond();
	endtask

	task automatic reg_read(input logic [7:0] p, output logic [7:0] d, output logic ok);
		ok = 1'b1;
		start_cond();
		put_byte({TARGET_ADDRESS, 1'b0}, ok);
		put_byte(p, ok);
		start_cond();
		put_byte({TARGET_ADDRESS, 1'b1}, ok);
		for (int i = 7; i >= 0; i--)
			get_bit(d[i]);
		put_bit(1'b1);
		stop_cond();
	endtask
endmodule

// >>> tb/tb_top.sv
/*
 * Testbench: the host model reaches the registers, the bench plays the
 * conversion engine and status logic. The range setting is raised for the
 * fault scenario only; offset binary keeps code order, so flags are unchanged.
 */
`timescale 1ns/1ps
module tb_top;
	import temp_limit_pkg::*;

	logic                 clk_sys_in;
	logic                 rst_n_in;
	logic                 scl;
	logic                 pull;
	logic                 sda_oe;
	logic                 sda_drv;
	logic                 range_sel;
	wire                  sda = !pull && (sda_oe ? sda_drv : 1'b1);
	temp_t [CHANNELS-1:0] temp;
	logic [CHANNELS-1:0]  valid, fault, high, low, crit;
	logic                 clear, hw, summary, alert_n, shut_n;
	int                   n_mismatch;
	int                   n_tests;

	always #4 clk_sys_in = ~clk_sys_in;

	smbus_host_model u_smbus_host_model (.scl_out(scl), .pull_out(pull), .sda_in(sda));

	temp_limit_shutdown u_temp_limit_shutdown (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_drv), .sda_oe_out(sda_oe), .temp_in(temp), .temp_valid_in(valid),
		.diode_fault_in(fault), .range_in(range_sel), .status_clear_in(clear),
		.hw_shutdown_in(hw), .high_status_out(high), .low_status_out(low),
		.critical_status_out(crit), .fault_summary_out(summary),
		.alert_out_n(alert_n), .shutdown_out_n(shut_n));

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic ok;
		u_smbus_host_model.reg_write(p, d, ok);
		chk("write ack", 8'h01, {7'h00, ok});
	endtask

	task automatic rd(input logic [7:0] p, input logic [7:0] exp);
		logic ok;
		logic [7:0] d;
		u_smbus_host_model.reg_read(p, d, ok);
		chk("read ack", 8'h01, {7'h00, ok});
		chk($sformatf("register %h", p), exp, d);
	endtask

	// Leaves the bench two edges after the result, when the pins have settled.
	task automatic eval(input logic [3:0] m, input logic [7:0] w, input logic [2:0] f);
		@(posedge clk_sys_in);
		#1;
		for (int c = 0; c < CHANNELS; c++)
			if (m[c])
				temp[c] = {w, f};
		valid = m;
		@(posedge clk_sys_in);
		#1 valid = '0;
		repeat (2) @(posedge clk_sys_in);
		#1;
	endtask

	task automatic pins(input logic [3:0] h, input logic a_n, input logic s_n);
		chk("high flags", {4'h0, h}, {4'h0, high});
		chk("alert pin", {7'h00, a_n}, {7'h00, alert_n});
		chk("shutdown pin", {7'h00, s_n}, {7'h00, shut_n});
	endtask

	task automatic clr;
		@(posedge clk_sys_in);
		#1 clear = 1'b1;
		@(posedge clk_sys_in);
		#1 clear = 1'b0;
		repeat (2) @(posedge clk_sys_in);
		#1;
		chk("all flags", 8'h00, {high | low, crit});
	endtask

	task automatic t_reset;
		logic [7:0] p [10] = '{8'h05, 8'h0B, 8'h06, 8'h13, 8'h19, 8'h1D, 8'h20, 8'h21, 8'h11, 8'h40};
		logic [7:0] e [10] = '{8'h55, 8'h55, 8'h00, 8'h00, 8'h55, 8'h00, 8'h55, 8'h0A, 8'h00, 8'h00};
		for (int i = 0; i < 10; i++)
			rd(p[i], e[i]);
		pins(4'h0, 1'b1, 1'b1);
		$display("test reset values done");
	endtask

	task automatic t_alias_scratch;
		wr(8'h0B, 8'h3C);
		rd(8'h05, 8'h3C);
		wr(8'h11, 8'hA5);
		wr(8'h12, 8'h5A);
		rd(8'h11, 8'hA5);
		rd(8'h12, 8'h5A);
		wr(8'h40, 8'hFF);
		rd(8'h40, 8'h00);
		wr(8'h05, 8'h55);
		$display("test alias and scratch done");
	endtask

	task automatic t_limits;
		wr(8'h07, 8'h40);
		wr(8'h13, 8'hBF);
		rd(8'h13, 8'hA0);
		eval(4'h2, 8'h40, 3'b101);
		pins(4'h0, 1'b1, 1'b1);
		eval(4'h2, 8'h40, 3'b110);
		pins(4'h2, 1'b0, 1'b1);
		wr(8'h08, 8'h10);
		wr(8'h14, 8'h20);
		eval(4'h2, 8'h10, 3'b010);
		chk("low flags", 8'h00, {4'h0, low});
		eval(4'h2, 8'h10, 3'b001);
		chk("low flags", 8'h02, {4'h0, low});
		wr(8'h15, 8'h4F);
		eval(4'hC, 8'h50, 3'b000);
		chk("high flags", 8'h06, {4'h0, high});
		clr();
		pins(4'h0, 1'b1, 1'b1);
		$display("test limits done");
	endtask

	task automatic t_shutdown;
		eval(4'h2, 8'h55, 3'b000);
		chk("critical flags", 8'h00, {4'h0, crit});
		eval(4'h2, 8'h55, 3'b001);
		chk("critical flags", 8'h02, {4'h0, crit});
		chk("shutdown pin", 8'h01, {7'h00, shut_n});
		wr(8'h1D, 8'h02);
		rd(8'h1D, 8'h02);
		eval(4'h2, 8'h55, 3'b001);
		chk("shutdown pin", 8'h00, {7'h00, shut_n});
		eval(4'h2, 8'h4B, 3'b000);
		chk("shutdown pin", 8'h00, {7'h00, shut_n});
		eval(4'h2, 8'h4A, 3'b111);
		chk("shutdown pin", 8'h01, {7'h00, shut_n});
		wr(8'h1D, 8'h09);
		wr(8'h30, 8'h20);
		eval(4'h1, 8'h30, 3'b000);
		chk("shutdown pin", 8'h01, {7'h00, shut_n});
		eval(4'h8, 8'h30, 3'b000);
		chk("shutdown pin", 8'h00, {7'h00, shut_n});
		eval(4'h8, 8'h15, 3'b000);
		chk("shutdown pin", 8'h01, {7'h00, shut_n});
		wr(8'h1D, 8'h00);
		@(posedge clk_sys_in);
		#1 hw = 1'b1;
		@(posedge clk_sys_in);
		#1 chk("shutdown pin", 8'h00, {7'h00, shut_n});
		hw = 1'b0;
		@(posedge clk_sys_in);
		#1 chk("shutdown pin", 8'h01, {7'h00, shut_n});
		clr();
		$display("test shutdown done");
	endtask

	task automatic t_fault;
		fault = 4'hF;
		range_sel = 1'b1;
		eval(4'hF, 8'h30, 3'b000);
		fault = 4'h0;
		chk("critical flags", 8'h08, {4'h0, crit});
		chk("fault summary", 8'h01, {7'h00, summary});
		chk("alert pin", 8'h00, {7'h00, alert_n});
		rd(8'h1B, 8'h0E);
		rd(8'h1B, 8'h00);
		chk("fault summary", 8'h00, {7'h00, summary});
		$display("test fault flags done");
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		repeat (100000) @(posedge clk_sys_in);
		n_mismatch++;
		report_and_stop();
	end

	initial
	begin
		clk_sys_in = 1'b0;
		rst_n_in = 1'b0;
		temp = '0;
		valid = '0;
		fault = '0;
		clear = 1'b0;
		hw = 1'b0;
		range_sel = 1'b0;
		n_mismatch = 0;
		n_tests = 0;
		repeat (8) @(posedge clk_sys_in);
		#1 rst_n_in = 1'b1;
		repeat (3) @(posedge clk_sys_in);
		#1;
		t_reset();
		t_alias_scratch();
		t_limits();
		t_shutdown();
		t_fault();
		report_and_stop();
	end
endmodule

// >>> tb/temp_limit_sva.sv
/*
 * Checker for the temperature limit and shutdown block, bound to its ports.
 * Assumes one clock domain and the one-edge flag and pin timing of the block.
 */
`timescale 1ns/1ps
module temp_limit_sva
#(
	parameter int unsigned CH = 4
)
(
	// Clock and reset
	input wire logic          clk_sys_in,
	input wire logic          rst_n_in,
	// Watched ports
	input wire logic [CH-1:0] temp_valid_in,
	input wire logic          status_clear_in,
	input wire logic          hw_shutdown_in,
	input wire logic [CH-1:0] high_status_out,
	input wire logic [CH-1:0] low_status_out,
	input wire logic [CH-1:0] critical_status_out,
	input wire logic          fault_summary_out,
	input wire logic          alert_out_n,
	input wire logic          shutdown_out_n
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	a_alert_tracks_flags:
	assert property (alert_out_n == !($past(|high_status_out) || $past(|low_status_out)
		|| $past(fault_summary_out))) else $error("alert pin disagrees with flags");
	a_hw_forces_shutdown:
	assert property (hw_shutdown_in |=> !shutdown_out_n) else $error("hw shutdown ignored");
	a_shut_needs_cause:
	assert property ($fell(shutdown_out_n) |-> $past(hw_shutdown_in) || $past(|critical_status_out))
		else $error("shutdown without cause");
	a_shut_release_hw:
	assert property ($rose(shutdown_out_n) |-> !$past(hw_shutdown_in))
		else $error("shutdown released under hw request");
	a_high_needs_eval:
	assert property ((high_status_out & ~$past(high_status_out) & ~$past(temp_valid_in)) == '0)
		else $error("high flag set without result");
	a_low_needs_eval:
	assert property ((low_status_out & ~$past(low_status_out) & ~$past(temp_valid_in)) == '0)
		else $error("low flag set without result");
	a_crit_holds_quiet:
	assert property (!(|temp_valid_in) && !status_clear_in |=> $stable(critical_status_out))
		else $error("critical flags moved without cause");
	a_clear_empties:
	assert property (status_clear_in && !(|temp_valid_in) |=>
		(high_status_out | low_status_out | critical_status_out) == '0)
		else $error("flags survive clear");

	c_shutdown: cover property ($fell(shutdown_out_n));
	c_alert: cover property ($fell(alert_out_n));
	c_fault: cover property ($rose(fault_summary_out));
endmodule

bind temp_limit_shutdown temp_limit_sva #(.CH(CH)) u_temp_limit_sva (
	.clk_sys_in(clk_sys_in),
	.rst_n_in(rst_n_in),
	.temp_valid_in(temp_valid_in),
	.status_clear_in(status_clear_in),
	.hw_shutdown_in(hw_shutdown_in),
	.high_status_out(high_status_out),
	.low_status_out(low_status_out),
	.critical_status_out(critical_status_out),
	.fault_summary_out(fault_summary_out),
	.alert_out_n(alert_out_n),
	.shutdown_out_n(shutdown_out_n)
);
